// file: include/ivm_pkg.sv
package ivm_pkg;

	// ----------------------------------------
	// vector numbers
	// ----------------------------------------
	localparam int IVM_VEC_W = 6;
	localparam int IVM_NUM_VECS = 36;
	localparam logic [5:0] IVM_VEC_RESET = 6'h00;
	localparam logic [5:0] IVM_VEC_NMI = 6'h01;
	localparam logic [5:0] IVM_VEC_VLM = 6'h02;
	localparam logic [5:0] IVM_VEC_CLK_FAIL = 6'h03;
	localparam logic [5:0] IVM_VEC_MVIO = 6'h04;
	localparam logic [5:0] IVM_VEC_RTC_COUNT_IRQ = 6'h05;
	localparam logic [5:0] IVM_VEC_RTC_PERIODIC_IRQ = 6'h06;
	localparam logic [5:0] IVM_VEC_CUSTOM = 6'h07;
	localparam logic [5:0] IVM_VEC_PORT_A = 6'h08;
	localparam logic [5:0] IVM_VEC_WT_OVF = 6'h09;
	localparam logic [5:0] IVM_VEC_WT_HUNF = 6'h0A;
	localparam logic [5:0] IVM_VEC_WT_CMP0 = 6'h0B;
	localparam logic [5:0] IVM_VEC_CAPT0 = 6'h0E;
	localparam logic [5:0] IVM_VEC_CAPT1 = 6'h0F;
	localparam logic [5:0] IVM_VEC_WAVE_OVF = 6'h10;
	localparam logic [5:0] IVM_VEC_WAVE_TRIG = 6'h11;
	localparam logic [5:0] IVM_VEC_TWI_CLIENT = 6'h12;
	localparam logic [5:0] IVM_VEC_TWI_HOST = 6'h13;
	localparam logic [5:0] IVM_VEC_SPI = 6'h14;
	localparam logic [5:0] IVM_VEC_SER0_RXC = 6'h15;
	localparam logic [5:0] IVM_VEC_PORT_D = 6'h18;
	localparam logic [5:0] IVM_VEC_COMP = 6'h19;
	localparam logic [5:0] IVM_VEC_CONV_RES = 6'h1A;
	localparam logic [5:0] IVM_VEC_CONV_WIN = 6'h1B;
	localparam logic [5:0] IVM_VEC_ZERO_CROSS = 6'h1C;
	localparam logic [5:0] IVM_VEC_PORT_C = 6'h1D;
	localparam logic [5:0] IVM_VEC_CAPT2 = 6'h1E;
	localparam logic [5:0] IVM_VEC_SER1_RXC = 6'h1F;
	localparam logic [5:0] IVM_VEC_PORT_F = 6'h22;
	localparam logic [5:0] IVM_VEC_EEPROM = 6'h23;

	// ----------------------------------------
	// system configuration registers
	// ----------------------------------------
	localparam logic [3:0] IVM_IDX_RESERVED_SLOT = 4'h0;
	localparam logic [3:0] IVM_IDX_SILICON_REVISION = 4'h1;
	localparam logic [3:0] IVM_IDX_GLOBAL_ENABLE = 4'h2;
	localparam logic [3:0] IVM_IDX_FLAGS_LO = 4'h3;
	localparam logic [3:0] IVM_IDX_FLAGS_HI = 4'h4;
	localparam logic [3:0] IVM_IDX_ENABLE_LO = 4'h5;
	localparam logic [3:0] IVM_IDX_ENABLE_HI = 4'h6;
	localparam logic [3:0] IVM_IDX_CTRL = 4'h7;
	localparam logic [3:0] IVM_IDX_VECTOR = 4'h8;
	localparam int IVM_ADDR_W = 6;
	localparam int IVM_MAJOR_MSB = 7;
	localparam int IVM_MAJOR_LSB = 4;
	localparam int IVM_MINOR_MSB = 3;
	localparam int IVM_MINOR_LSB = 0;
	localparam int IVM_CTRL_SPLIT_BIT = 0;
	localparam logic [31:0] IVM_RESET_WORD = 32'h0000_0000;
	localparam logic [35:0] IVM_RESET_FLAGS = 36'h0_0000_0000;

	typedef enum logic [1:0] {
		IVM_BUS_IDLE = 2'b00,
		IVM_BUS_ACK = 2'b01
	} ivm_bus_state_type;

endpackage

// file: verification/ivm_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// processor core taking interrupt vectors
// ----------------------------------------
module ivm_core_model
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic irq_in,
	input wire logic [6:0] addr_in,
	input wire logic [3:0] lat_in,
	output logic taken_out,
	output logic [6:0] fetch_addr_out
);
	logic [3:0] wait_q;

	// a busy core lets lat_in cycles pass before it fetches; it keeps
	// fetching while the request stands, since it never clears flags itself
	always_ff @(posedge clk_in)
	begin
		taken_out <= 1'b0;
		if (!rstn_in)
		begin
			wait_q <= 4'h0;
			fetch_addr_out <= 7'h7F;
		end
		else if (!irq_in)
			wait_q <= 4'h0;
		else if (wait_q >= lat_in)
		begin
			wait_q <= 4'h0;
			taken_out <= 1'b1;
			fetch_addr_out <= addr_in;
		end
		else
			wait_q <= wait_q + 4'h1;
	end
endmodule

// file: verification/tb_interrupt_vector_map_and_revision.sv
`timescale 1ns/1ps
module tb_interrupt_vector_map_and_revision
	import ivm_pkg::*;
;
	logic clk_in, rstn_in, rd, wr, wait_r, irq, taken;
	logic [5:0] address, vnum;
	logic [31:0] wdata, rdata, q;
	logic [37:0] src, m;
	logic [63:0] r;
	logic [6:0] vaddr, fetch;
	logic [3:0] lat;
	int num_errors, n_checks, e;
	logic [31:0] seed = 32'h0001_6AAA;
	// source bit to vector number; port and serial bits are per instance
	int map_n[38] = '{3, 4, 5, 5, 6, 7, 8, 24, 29, 34, 9, 9, 10, 11, 12, 13, 11, 12, 13,
		14, 15, 30, 16, 17, 18, 19, 20, 21, 31, 22, 32, 23, 33, 25, 26, 27, 28, 35};
	logic [37:0] split_only = 38'h00_0007_0800;
	logic [37:0] normal_only = 38'h00_0000_E400;

	ivm_vector_map #(.MAJOR_REV(4'h2), .MINOR_REV(4'h5)) ivm_vector_map_inst (
		.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(address), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
		.clock_failure_detect_in(src[0]), .multi_voltage_io_irq_in(src[1]),
		.rtc_overflow_in(src[2]), .rtc_compare_in(src[3]), .rtc_periodic_irq_in(src[4]),
		.custom_logic_irq_in(src[5]), .port_pin_irq_in(src[9:6]),
		.wide_timer_overflow_irq_in(src[10]), .wide_timer_low_underflow_irq_in(src[11]),
		.wide_timer_high_underflow_irq_in(src[12]), .wide_timer_compare_irq_in(src[15:13]),
		.wide_timer_low_compare_irq_in(src[18:16]), .capture_timer_irq_in(src[21:19]),
		.waveform_timer_overflow_irq_in(src[22]), .waveform_timer_trigger_irq_in(src[23]),
		.two_wire_client_irq_in(src[24]), .two_wire_host_irq_in(src[25]),
		.serial_periph_irq_in(src[26]), .serial_rx_complete_irq_in(src[28:27]),
		.serial_tx_empty_irq_in(src[30:29]), .serial_tx_complete_irq_in(src[32:31]),
		.comparator_irq_in(src[33]), .converter_result_irq_in(src[34]),
		.converter_window_irq_in(src[35]), .zero_cross_irq_in(src[36]),
		.eeprom_ready_irq_in(src[37]), .vector_taken_in(taken), .irq_out(irq),
		.vector_number_out(vnum), .vector_word_addr_out(vaddr));

	ivm_core_model ivm_core_model_inst (.clk_in(clk_in), .rstn_in(rstn_in), .irq_in(irq),
		.addr_in(vaddr), .lat_in(lat), .taken_out(taken), .fetch_addr_out(fetch));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// a high-underflow event has no vector while the timer is not split
	function automatic int vec_of(input int i, input int split);
		if (i == 12 && split == 0)
			return -1;
		return map_n[i];
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		wr <= w;
		rd <= !w;
		address <= a;
		wdata <= d;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (wait_r !== 1'b0 && n < 20);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (wait_r !== 1'b0)
		begin
			num_errors++;
			print_verdict();
		end
	endtask

	task automatic pulse(input logic [37:0] mask);
		@(posedge clk_in);
		src <= mask;
		@(posedge clk_in);
		src <= '0;
		repeat (2) @(posedge clk_in);
	endtask

	task automatic clr();
		av(1'b1, 6'h0C, 32'hFFFF_FFFF);
		av(1'b1, 6'h10, 32'h0000_000F);
	endtask

	task automatic expect_vec(input int v);
		int x;
		int n;
		x = (v < 0) ? 0 : v;
		chk("irq", {31'h0, irq}, {31'h0, v >= 0});
		chk("number", {26'h0, vnum}, x);
		chk("word address", {25'h0, vaddr}, 2 * x);
		if (v >= 0)
		begin
			n = 0;
			do
			begin
				@(posedge clk_in);
				n++;
			end
			while (taken !== 1'b1 && n < 20);
			if (taken !== 1'b1)
			begin
				num_errors++;
				print_verdict();
			end
			else
			begin
				chk("fetched address", {25'h0, fetch}, 2 * x);
			end
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	initial
	begin
		{rstn_in, rd, wr, address, wdata, src, lat, num_errors, n_checks} = '0;
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		av(1'b0, 6'h04, 32'h0);
		chk("revision", q, 32'h0000_0025);
		av(1'b1, 6'h04, xs());
		av(1'b0, 6'h04, 32'h0);
		chk("revision after write", q, 32'h0000_0025);
		av(1'b1, 6'h00, xs());
		av(1'b0, 6'h00, 32'h0);
		chk("reserved slot", q, 32'h0);
		av(1'b0, 6'h24, 32'h0);
		chk("unmapped", q, 32'h0);
		av(1'b1, 6'h14, 32'hFFFF_FFFF);
		av(1'b1, 6'h18, 32'h0000_000F);
		pulse(38'h20_0000_0000);
		expect_vec(-1);
		av(1'b0, 6'h10, 32'h0);
		chk("flags high", q, 32'h0000_0008);
		av(1'b1, 6'h08, 32'h0000_0001);
		@(posedge clk_in);
		expect_vec(35);
		av(1'b0, 6'h20, 32'h0);
		chk("vector status", q, 32'h0000_8046);
		av(1'b1, 6'h18, 32'h0);
		@(posedge clk_in);
		expect_vec(-1);
		clr();
		av(1'b1, 6'h18, 32'h0000_000F);
		// each source alone, in normal mode but the split_only ones, then in split mode but the normal_only ones
		for (int s = 0; s < 2; s++)
		begin
			av(1'b1, 6'h1C, s);
			for (int i = 0; i < 38; i++)
				if (!(s ? normal_only[i] : split_only[i]))
				begin
					q = xs();
					lat <= q[3:0];
					pulse(38'h1 << i);
					expect_vec(vec_of(i, s));
					clr();
				end
		end
		// several sources at once: the lowest vector number wins
		av(1'b1, 6'h1C, 32'h0);
		repeat (8)
		begin
			r = {xs(), xs()};
			m = r[37:0] & ~split_only;
			e = -1;
			for (int i = 0; i < 38; i++)
				if (m[i] && vec_of(i, 0) >= 0 && (e < 0 || vec_of(i, 0) < e))
					e = vec_of(i, 0);
			pulse(m);
			expect_vec(e);
			clr();
		end
		// a second reset in mid-run must drop flags, enables and read data
		pulse(38'h00_0000_0001);
		expect_vec(3);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		expect_vec(-1);
		chk("readdata after reset", rdata, 32'h0);
		av(1'b0, 6'h08, 32'h0);
		chk("global enable after reset", q, 32'h0);
		print_verdict();
	end
endmodule

// file: verilog/ivm_vector_encoder.sv
`timescale 1ns/1ps
module ivm_vector_encoder
	import ivm_pkg::*;
#(
	parameter int NUM_VECS = 36
)
(
	input wire logic [NUM_VECS-1:0] request_in,
	output logic active_out,
	output logic [IVM_VEC_W-1:0] number_out,
	output logic [IVM_VEC_W:0] word_addr_out
);
	// lowest numbered request wins; priority beyond that is not this block's job
	always_comb
	begin
		active_out = 1'b0;
		number_out = '0;
		for (int i = NUM_VECS - 1; i >= 0; i--)
		begin
			if (request_in[i])
			begin
				active_out = 1'b1;
				number_out = IVM_VEC_W'(i);
			end
		end
		word_addr_out = {number_out, 1'b0};
	end
endmodule

// file: verilog/ivm_vector_map.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - clock failure event goes to vector 3 at word 0x06.
// - rtc overflow and compare share word 0x0A; periodic uses 0x0C.
// - vector 9 at 0x12: overflow normally, low underflow when split.
// - vector 10 at 0x14 silent in normal mode, high underflow when split.
// - words 0x16..0x1A carry compare 0..2, low compares when split.
// - capture timers 0,1,2 each one vector at 0x1C, 0x1E, 0x3C.
// - waveform timer overflow at 0x20, trigger at 0x22.
// - two-wire client events at 0x24, host events at 0x26.
// - serial units: rx, empty, tx-done vectors from 0x2A and 0x3E.
// - port pin vectors: A 0x10, D 0x30, C 0x3A, F 0x44.
// - converter result ready at 0x34, window compare at 0x36.
// - eeprom ready is last vector 35 at word 0x46.
// - single sources: mvio 0x08, logic 0x0E, spi 0x28, comp 0x32, zcd 0x38.
// - revision register at offset 1 is read-only.
// - bits 7:4 hold major revision, 1 means first letter.
// - bits 3:0 hold minor revision as plain binary.
// - flags set on their condition even when the enable is off.
// - request only while flag, enable and global enable are all set.
// - vectors 0..2 reserved for reset, nmi, level monitor at 0x00..0x04.
module ivm_vector_map
	import ivm_pkg::*;
#(
	parameter logic [3:0] MAJOR_REV = 4'h1, // arbitrary value
	parameter logic [3:0] MINOR_REV = 4'h0 // arbitrary value
)
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [IVM_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic clock_failure_detect_in,
	input wire logic multi_voltage_io_irq_in,
	input wire logic rtc_overflow_in,
	input wire logic rtc_compare_in,
	input wire logic rtc_periodic_irq_in,
	input wire logic custom_logic_irq_in,
	input wire logic [3:0] port_pin_irq_in,
	input wire logic wide_timer_overflow_irq_in,
	input wire logic wide_timer_low_underflow_irq_in,
	input wire logic wide_timer_high_underflow_irq_in,
	input wire logic [2:0] wide_timer_compare_irq_in,
	input wire logic [2:0] wide_timer_low_compare_irq_in,
	input wire logic [2:0] capture_timer_irq_in,
	input wire logic waveform_timer_overflow_irq_in,
	input wire logic waveform_timer_trigger_irq_in,
	input wire logic two_wire_client_irq_in,
	input wire logic two_wire_host_irq_in,
	input wire logic serial_periph_irq_in,
	input wire logic [1:0] serial_rx_complete_irq_in,
	input wire logic [1:0] serial_tx_empty_irq_in,
	input wire logic [1:0] serial_tx_complete_irq_in,
	input wire logic comparator_irq_in,
	input wire logic converter_result_irq_in,
	input wire logic converter_window_irq_in,
	input wire logic zero_cross_irq_in,
	input wire logic eeprom_ready_irq_in,
	input wire logic vector_taken_in,
	output logic irq_out,
	output logic [IVM_VEC_W-1:0] vector_number_out,
	output logic [IVM_VEC_W:0] vector_word_addr_out
);

	// ----------------------------------------
	// source to vector mapping
	// ----------------------------------------
	logic [IVM_NUM_VECS-1:0] event_vec;
	logic split_mode;

	always_comb
	begin
		event_vec = '0;
		// vectors 0..2 are owned by reset, nmi and level monitor logic elsewhere
		event_vec[IVM_VEC_RESET] = 1'b0;
		event_vec[IVM_VEC_NMI] = 1'b0;
		event_vec[IVM_VEC_VLM] = 1'b0;
		event_vec[IVM_VEC_CLK_FAIL] = clock_failure_detect_in;
		event_vec[IVM_VEC_MVIO] = multi_voltage_io_irq_in;
		event_vec[IVM_VEC_RTC_COUNT_IRQ] = rtc_overflow_in | rtc_compare_in;
		event_vec[IVM_VEC_RTC_PERIODIC_IRQ] = rtc_periodic_irq_in;
		event_vec[IVM_VEC_CUSTOM] = custom_logic_irq_in;
		event_vec[IVM_VEC_PORT_A] = port_pin_irq_in[0];
		event_vec[IVM_VEC_PORT_D] = port_pin_irq_in[1];
		event_vec[IVM_VEC_PORT_C] = port_pin_irq_in[2];
		event_vec[IVM_VEC_PORT_F] = port_pin_irq_in[3];
		event_vec[IVM_VEC_WT_OVF] = split_mode ? wide_timer_low_underflow_irq_in
			: wide_timer_overflow_irq_in;
		event_vec[IVM_VEC_WT_HUNF] = split_mode & wide_timer_high_underflow_irq_in;
		for (int c = 0; c < 3; c++)
		begin
			event_vec[int'(IVM_VEC_WT_CMP0) + c] = split_mode ? wide_timer_low_compare_irq_in[c]
				: wide_timer_compare_irq_in[c];
		end
		event_vec[IVM_VEC_CAPT0] = capture_timer_irq_in[0];
		event_vec[IVM_VEC_CAPT1] = capture_timer_irq_in[1];
		event_vec[IVM_VEC_CAPT2] = capture_timer_irq_in[2];
		event_vec[IVM_VEC_WAVE_OVF] = waveform_timer_overflow_irq_in;
		event_vec[IVM_VEC_WAVE_TRIG] = waveform_timer_trigger_irq_in;
		event_vec[IVM_VEC_TWI_CLIENT] = two_wire_client_irq_in;
		event_vec[IVM_VEC_TWI_HOST] = two_wire_host_irq_in;
		event_vec[IVM_VEC_SPI] = serial_periph_irq_in;
		event_vec[int'(IVM_VEC_SER0_RXC)] = serial_rx_complete_irq_in[0];
		event_vec[int'(IVM_VEC_SER0_RXC) + 1] = serial_tx_empty_irq_in[0];
		event_vec[int'(IVM_VEC_SER0_RXC) + 2] = serial_tx_complete_irq_in[0];
		event_vec[int'(IVM_VEC_SER1_RXC)] = serial_rx_complete_irq_in[1];
		event_vec[int'(IVM_VEC_SER1_RXC) + 1] = serial_tx_empty_irq_in[1];
		event_vec[int'(IVM_VEC_SER1_RXC) + 2] = serial_tx_complete_irq_in[1];
		event_vec[IVM_VEC_COMP] = comparator_irq_in;
		event_vec[IVM_VEC_CONV_RES] = converter_result_irq_in;
		event_vec[IVM_VEC_CONV_WIN] = converter_window_irq_in;
		event_vec[IVM_VEC_ZERO_CROSS] = zero_cross_irq_in;
		event_vec[IVM_VEC_EEPROM] = eeprom_ready_irq_in;
	end

	// ----------------------------------------
	// register bus and flag state
	// ----------------------------------------
	ivm_bus_state_type bus_q, bus_d;
	logic [IVM_NUM_VECS-1:0] flags_q, flags_d;
	logic [IVM_NUM_VECS-1:0] enable_q, enable_d;
	logic global_en_q, global_en_d;
	logic split_q, split_d;
	logic [31:0] rdata_q, rdata_d;
	logic [IVM_NUM_VECS-1:0] pend_vec;
	logic enc_active;
	logic [IVM_VEC_W-1:0] enc_number;
	logic [IVM_VEC_W:0] enc_addr;
	logic [3:0] idx;
	logic wr_hit;
	logic [31:0] rev_word;

	assign split_mode = split_q;
	assign idx = avs_address_in[5:2];
	assign rev_word = {24'h00_0000, MAJOR_REV, MINOR_REV};
	// a write lands on the edge where the master sees waitrequest low, not earlier
	assign wr_hit = avs_write_in & (bus_q == IVM_BUS_ACK);

	// merge byte lanes of a write into an old word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
			begin
				r[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return r;
	endfunction

	always_comb
	begin
		logic [31:0] clr_lo;
		logic [31:0] clr_hi;
		clr_lo = '0;
		clr_hi = '0;
		bus_d = IVM_BUS_IDLE;
		flags_d = flags_q;
		enable_d = enable_q;
		global_en_d = global_en_q;
		split_d = split_q;
		rdata_d = rdata_q;
		if (bus_q == IVM_BUS_IDLE && (avs_read_in || avs_write_in))
		begin
			bus_d = IVM_BUS_ACK;
		end
		if (wr_hit)
		begin
			case (idx)
				IVM_IDX_GLOBAL_ENABLE: if (avs_byteenable_in[0])
				begin
					global_en_d = avs_writedata_in[0];
				end
				IVM_IDX_FLAGS_LO: clr_lo = merge_bytes('0, avs_writedata_in, avs_byteenable_in);
				IVM_IDX_FLAGS_HI: clr_hi = merge_bytes('0, avs_writedata_in, avs_byteenable_in);
				IVM_IDX_ENABLE_LO: enable_d[31:0] = merge_bytes(enable_q[31:0],
					avs_writedata_in, avs_byteenable_in);
				IVM_IDX_ENABLE_HI: if (avs_byteenable_in[0])
				begin
					enable_d[35:32] = avs_writedata_in[3:0];
				end
				IVM_IDX_CTRL: if (avs_byteenable_in[0])
				begin
					split_d = avs_writedata_in[IVM_CTRL_SPLIT_BIT];
				end
				// reserved slot and revision word swallow writes
				default: ;
			endcase
		end
		// write-one-to-clear, but a new event in the same cycle wins
		flags_d = (flags_q & ~{clr_hi[3:0], clr_lo}) | event_vec;
		flags_d[2:0] = 3'b000;
		if (bus_q == IVM_BUS_IDLE && avs_read_in)
		begin
			case (idx)
				IVM_IDX_RESERVED_SLOT: rdata_d = IVM_RESET_WORD;
				IVM_IDX_SILICON_REVISION: rdata_d = rev_word;
				IVM_IDX_GLOBAL_ENABLE: rdata_d = {31'h0000_0000, global_en_q};
				IVM_IDX_FLAGS_LO: rdata_d = flags_q[31:0];
				IVM_IDX_FLAGS_HI: rdata_d = {28'h000_0000, flags_q[35:32]};
				IVM_IDX_ENABLE_LO: rdata_d = enable_q[31:0];
				IVM_IDX_ENABLE_HI: rdata_d = {28'h000_0000, enable_q[35:32]};
				IVM_IDX_CTRL: rdata_d = {31'h0000_0000, split_q};
				IVM_IDX_VECTOR: rdata_d = {16'h0000, enc_active, 8'h00, enc_addr};
				default: rdata_d = IVM_RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			bus_q <= IVM_BUS_IDLE;
			flags_q <= IVM_RESET_FLAGS;
			enable_q <= IVM_RESET_FLAGS;
			global_en_q <= 1'b0;
			split_q <= 1'b0;
			rdata_q <= IVM_RESET_WORD;
		end
		else
		begin
			bus_q <= bus_d;
			flags_q <= flags_d;
			enable_q <= enable_d;
			global_en_q <= global_en_d;
			split_q <= split_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// request and vector output
	// ----------------------------------------
	// vector_taken_in is a hint for the core only; flags clear through software
	assign pend_vec = flags_q & enable_q & {IVM_NUM_VECS{global_en_q}};

	ivm_vector_encoder #(
		.NUM_VECS(IVM_NUM_VECS)
	) u_enc (
		.request_in(pend_vec),
		.active_out(enc_active),
		.number_out(enc_number),
		.word_addr_out(enc_addr)
	);

	assign irq_out = enc_active;
	assign vector_number_out = enc_number;
	assign vector_word_addr_out = enc_addr;
	assign avs_readdata_out = rdata_q;
	assign avs_waitrequest_out = (bus_q == IVM_BUS_IDLE); // answer one cycle after request

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence clk_fail_seq;
		clock_failure_detect_in ##1 (global_en_q && enable_q[3]);
	endsequence

	clk_fail_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		clk_fail_seq |-> irq_out)
		else $error("clock failure flag did not request");
	hunf_normal_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(!$past(split_q) && !$past(flags_q[10])) |-> !flags_q[10])
		else $error("high underflow vector set in normal mode");
	flag_sticky_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		($past(rstn_in) && $past(event_vec[5])) |-> flags_q[5])
		else $error("rtc event did not set flag");
	req_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		irq_out |-> (global_en_q && (pend_vec != '0)))
		else $error("request without enables");
	req_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(irq_out && $stable(enable_q) && $stable(global_en_q) && !wr_hit) |=> irq_out)
		else $error("request dropped while flag set");
	addr_twice_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		irq_out |-> (vector_word_addr_out == {vector_number_out, 1'b0}))
		else $error("vector word address not twice the number");
	low_vecs_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		flags_q[2:0] == 3'b000)
		else $error("reserved vectors flagged");
	rev_read_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(avs_read_in && !avs_waitrequest_out && $past(idx) == IVM_IDX_SILICON_REVISION
			&& $past(avs_read_in)) |-> avs_readdata_out == rev_word)
		else $error("revision read wrong");
	eeprom_last_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(pend_vec == 36'h8_0000_0000) |-> (vector_word_addr_out == 7'h46))
		else $error("eeprom vector misplaced");
	rtc_merge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rtc_compare_in |=> flags_q[IVM_VEC_RTC_COUNT_IRQ])
		else $error("rtc compare not merged onto the counter vector");
	split_unf_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(split_q && wide_timer_low_underflow_irq_in) |=> flags_q[IVM_VEC_WT_OVF])
		else $error("low underflow not on vector 9 in split mode");
	ser1_empty_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		serial_tx_empty_irq_in[1] |=> flags_q[int'(IVM_VEC_SER1_RXC) + 1])
		else $error("second serial empty event not on its vector");
endmodule
